// *** link_mon_pkg.sv ***
// Purpose: Shared constants and types of the link error monitor.
// Assumes: 20 MHz aclk, AXI4-Lite register access with 32-bit data.
// Notes: Offsets are byte addresses on the register bus.
package link_mon_pkg;
  // Clock and monitoring time unit.
  localparam int CLK_NS = 50;
  localparam int UNIT_NS = 1000000;
  localparam int UNIT_CYC = UNIT_NS / CLK_NS;
  localparam logic [7:0] MON_TIME_RST = 8'h05;
  localparam logic [2:0] MASTER_STN = 3'h0;
  // Error codes.
  localparam logic [7:0] E_NORESP = 8'h01;
  localparam logic [7:0] E_STN_M = 8'h02;
  localparam logic [7:0] E_CNT_M = 8'h03;
  localparam logic [7:0] E_FMT_S = 8'h04;
  localparam logic [7:0] E_MTMO = 8'h11;
  localparam logic [7:0] E_FMT_M = 8'h14;
  localparam logic [7:0] E_ABSENT = 8'h21;
  localparam logic [7:0] E_STN_S = 8'h22;
  localparam logic [7:0] E_CNT_S = 8'h23;
  localparam logic [7:0] E_NOPARM = 8'h31;
  // Register byte addresses.
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_STN = 8'h04;
  localparam logic [7:0] A_MON = 8'h08;
  localparam logic [7:0] A_FLAGS = 8'h0C;
  localparam logic [7:0] A_IRQ_ST = 8'h10;
  localparam logic [7:0] A_IRQ_MASK = 8'h14;
  localparam logic [7:0] A_ERR_LO = 8'h20;
  localparam logic [7:0] A_ERR_HI = 8'h3C;
  // Field positions.
  localparam int C_RUN = 0;
  localparam int C_CHSEL = 1;
  localparam int F_PARAM = 0;
  localparam int F_CH1 = 1;
  localparam int F_CH2 = 2;
  localparam int F_MASTER = 3;
  localparam int F_SLAVE = 4;
  localparam int F_ACTIVE = 11;
  localparam int I_SEQ = 0;
  localparam int I_CH1 = 1;
  localparam int I_CH2 = 2;
  // Bus responses.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  // Supervision phase of the polling cycle.
  typedef enum logic [1:0] {PH_IDLE, PH_RSP, PH_REQ} phase_t;
endpackage

// *** err_mem_if.sv ***
// Purpose: Port bundle between the monitor and its error-code store.
// Assumes: One write and one registered read per clock.
// Notes: Addresses are station numbers.
`timescale 1ns/10ps
`default_nettype none
interface err_mem_if;
  logic wr_en;
  logic [2:0] wr_addr;
  logic [7:0] wr_data;
  logic [2:0] rd_addr;
  logic [7:0] rd_data;
  modport user (output wr_en, wr_addr, wr_data, rd_addr, input rd_data);
  modport mem (input wr_en, wr_addr, wr_data, rd_addr, output rd_data);
endinterface
`default_nettype wire

// *** err_code_mem.sv ***
// Purpose: Eight 8-bit error-code words, one per station.
// Assumes: Synchronous active-low reset clears every word.
// Notes: Read data are registered; a same-cycle write reads old data.
`timescale 1ns/10ps
`default_nettype none
module err_code_mem (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Access port.
  err_mem_if.mem m
);
  typedef struct packed {
    logic [7:0][7:0] word;
    logic [7:0] rd;
  } mem_st_t;

  mem_st_t s_r;
  mem_st_t s_nxt;

  // Write the station word and fetch the addressed one.
  always_comb begin
    s_nxt = s_r;
    if (m.wr_en) begin
      s_nxt.word[m.wr_addr] = m.wr_data;
    end
    s_nxt.rd = s_r.word[m.rd_addr];
  end

  // State register.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign m.rd_data = s_r.rd;
endmodule
`default_nettype wire

// *** multidrop_link_error_monitor.sv ***
// Purpose: Error detection and status for one station of a polled
//   multidrop network, with an AXI4-Lite register slave.
// Assumes: A frame decoder on aclk reports each frame on the line as a
//   one-cycle frm_valid pulse with its fields.
// Notes: Flags are readable only; link flags clear when run is low, channel flags on a control write.
// How it works
// R1: Master logs 01H on slave answer timeout.
// R2: Wrong responder: master 02H, observers 22H.
// R3: Counter mismatch: master 03H, observers 23H.
// R4: Malformed slave message logs 04H.
// R5: Slave logs 11H when master stops polling.
// R6: Malformed master message logs 14H.
// R7: Observer logs 21H for an absent slave.
// R8: Request before parameters logs 31H on self.
// R9: Code goes into faulty station's word.
// R10: Master fault flag, kept by slaves only.
// R11: Slave flags; never set for own faults.
// R12: Transfer-active flag while link runs.
// R13: Separate serial fault flag per channel.
// R14: Software picks the serial channel.
// R15: Readable parameter setting flag.
// R16: Station zero is master, others slaves.
// R17: One error-code word per station.
// R18: Monitoring time defaults to five units.
// R19: Error codes are eight bits wide.
//
// Design decisions made here: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/10ps
`default_nettype none
module multidrop_link_error_monitor #(
  parameter int unsigned UNIT_CYCLES = link_mon_pkg::UNIT_CYC
) (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write channels.
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read channels.
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Decoded frames from the line.
  input wire logic frm_valid,
  input wire logic frm_is_req,
  input wire logic frm_is_param,
  input wire logic [2:0] frm_src,
  input wire logic [2:0] frm_dst,
  input wire logic [7:0] frm_cnt,
  input wire logic frm_fmt_ok,
  // Serial channel faults.
  input wire logic ch1_fault,
  input wire logic ch2_fault,
  // Channel steering and interrupt.
  output logic channel_select_bit,
  output logic irq
);
  typedef struct packed {
    logic aw_hold;
    logic [7:0] awa;
    logic w_hold;
    logic [31:0] wd;
    logic [3:0] ws;
    logic bvalid;
    logic [1:0] bresp;
    logic rd_pend;
    logic [7:0] ara;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic run;
    logic chsel;
    logic [2:0] station;
    logic [7:0] mon_time;
    logic [2:0] irq_st;
    logic [2:0] irq_mask;
    logic params_rcvd;
    logic active;
    logic ch1_err;
    logic ch2_err;
    logic master_flag;
    logic [6:0] slave_flags;
    link_mon_pkg::phase_t phase;
    logic [2:0] exp_dst;
    logic [7:0] exp_cnt;
    logic [31:0] pre;
    logic [7:0] units;
  } mon_st_t;

  mon_st_t s_r;
  mon_st_t s_nxt;
  logic err_v;
  logic [2:0] err_stn;
  logic [7:0] err_code;
  logic restart;
  logic is_master;
  logic expire;
  logic from_peer;
  logic [11:0] flags;

  err_mem_if em ();

  err_code_mem u_mem (
    .aclk(aclk),
    .aresetn(aresetn),
    .m(em.mem)
  );

  // An address gets an OKAY response only if it names a register word.
  function automatic logic mapped(input logic [7:0] a);
    logic ok;
    ok = 1'b0;
    if (a[1:0] != 2'h0) begin
      ok = 1'b0;
    end else if (a <= link_mon_pkg::A_IRQ_MASK) begin
      ok = 1'b1;
    end else if (a >= link_mon_pkg::A_ERR_LO &&
                 a <= link_mon_pkg::A_ERR_HI) begin
      ok = 1'b1;
    end
    return ok;
  endfunction

  // Station role and timer state.
  assign is_master = (s_r.station == link_mon_pkg::MASTER_STN); // R16
  assign expire = (s_r.phase != link_mon_pkg::PH_IDLE) &&
                  (s_r.units >= s_r.mon_time);
  // A slave ignores its own answers, they carry no news.
  assign from_peer = (frm_src != link_mon_pkg::MASTER_STN) &&
                     (is_master || frm_src != s_r.station);

  // Readable status word.
  always_comb begin
    flags = '0;
    flags[link_mon_pkg::F_PARAM] =
      is_master ? s_r.run : s_r.params_rcvd; // R15
    flags[link_mon_pkg::F_CH1] = s_r.ch1_err;
    flags[link_mon_pkg::F_CH2] = s_r.ch2_err;
    flags[link_mon_pkg::F_MASTER] = s_r.master_flag;
    flags[link_mon_pkg::F_SLAVE +: 7] = s_r.slave_flags;
    flags[link_mon_pkg::F_ACTIVE] = s_r.active;
  end

  // Bus handshakes, register writes and link supervision.
  always_comb begin
    s_nxt = s_r;
    err_v = 1'b0;
    err_stn = 3'h0;
    err_code = 8'h00;
    restart = 1'b0;
    // Address and data are latched separately, in either order.
    if (awvalid && awready) begin
      s_nxt.aw_hold = 1'b1;
      s_nxt.awa = awaddr;
    end
    if (wvalid && wready) begin
      s_nxt.w_hold = 1'b1;
      s_nxt.wd = wdata;
      s_nxt.ws = wstrb;
    end
    if (s_r.bvalid && bready) begin
      s_nxt.bvalid = 1'b0;
    end
    if (s_r.aw_hold && s_r.w_hold && !s_r.bvalid) begin
      s_nxt.aw_hold = 1'b0;
      s_nxt.w_hold = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = mapped(s_r.awa) ? link_mon_pkg::RESP_OKAY :
                    link_mon_pkg::RESP_DECERR;
      if (s_r.ws[0]) begin
        if (s_r.awa == link_mon_pkg::A_CTRL) begin
          s_nxt.run = s_r.wd[link_mon_pkg::C_RUN];
          s_nxt.chsel = s_r.wd[link_mon_pkg::C_CHSEL]; // R14
          s_nxt.ch1_err = 1'b0;
          s_nxt.ch2_err = 1'b0;
        end else if (s_r.awa == link_mon_pkg::A_STN) begin
          s_nxt.station = s_r.wd[2:0];
        end else if (s_r.awa == link_mon_pkg::A_MON) begin
          s_nxt.mon_time = s_r.wd[7:0]; // R18
        end else if (s_r.awa == link_mon_pkg::A_IRQ_ST) begin
          s_nxt.irq_st = s_r.irq_st & ~s_r.wd[2:0];
        end else if (s_r.awa == link_mon_pkg::A_IRQ_MASK) begin
          s_nxt.irq_mask = s_r.wd[2:0];
        end
      end
    end
    // Reads answer two cycles after the address is taken.
    if (s_r.rvalid && rready) begin
      s_nxt.rvalid = 1'b0;
    end
    if (arvalid && arready) begin
      s_nxt.rd_pend = 1'b1;
      s_nxt.ara = araddr;
    end
    if (s_r.rd_pend) begin
      s_nxt.rd_pend = 1'b0;
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp = mapped(s_r.ara) ? link_mon_pkg::RESP_OKAY :
                    link_mon_pkg::RESP_DECERR;
      s_nxt.rdata = 32'h00000000;
      if (!mapped(s_r.ara)) begin
        s_nxt.rdata = 32'h00000000;
      end else if (s_r.ara == link_mon_pkg::A_CTRL) begin
        s_nxt.rdata[link_mon_pkg::C_RUN] = s_r.run;
        s_nxt.rdata[link_mon_pkg::C_CHSEL] = s_r.chsel;
      end else if (s_r.ara == link_mon_pkg::A_STN) begin
        s_nxt.rdata[2:0] = s_r.station;
      end else if (s_r.ara == link_mon_pkg::A_MON) begin
        s_nxt.rdata[7:0] = s_r.mon_time;
      end else if (s_r.ara == link_mon_pkg::A_FLAGS) begin
        s_nxt.rdata[11:0] = flags;
      end else if (s_r.ara == link_mon_pkg::A_IRQ_ST) begin
        s_nxt.rdata[2:0] = s_r.irq_st;
      end else if (s_r.ara == link_mon_pkg::A_IRQ_MASK) begin
        s_nxt.rdata[2:0] = s_r.irq_mask;
      end else begin
        s_nxt.rdata[7:0] = em.rd_data; // R17
      end
    end
    // Link supervision; only one fault is logged per cycle.
    if (!s_r.run) begin
      s_nxt.phase = link_mon_pkg::PH_IDLE;
      s_nxt.params_rcvd = 1'b0;
      s_nxt.active = 1'b0;
      s_nxt.master_flag = 1'b0;
      s_nxt.slave_flags = 7'h00;
      restart = 1'b1;
    end else if (frm_valid && frm_is_req &&
                 frm_src == link_mon_pkg::MASTER_STN) begin
      if (!frm_fmt_ok) begin
        if (!is_master) begin
          err_v = 1'b1; // R6
          err_code = link_mon_pkg::E_FMT_M;
          err_stn = link_mon_pkg::MASTER_STN;
        end
      end else begin
        s_nxt.active = 1'b1; // R12
        restart = 1'b1;
        s_nxt.exp_dst = frm_dst;
        s_nxt.exp_cnt = frm_cnt;
        s_nxt.phase = link_mon_pkg::PH_RSP;
        if (!is_master && frm_is_param) begin
          s_nxt.params_rcvd = 1'b1;
        end
        if (!is_master && frm_dst == s_r.station) begin
          // Our own answer is not seen, so wait for the next poll.
          s_nxt.phase = link_mon_pkg::PH_REQ;
          if (!s_r.params_rcvd && !frm_is_param) begin
            err_v = 1'b1; // R8
            err_code = link_mon_pkg::E_NOPARM;
            err_stn = s_r.station;
          end
        end
      end
    end else if (frm_valid && !frm_is_req && from_peer) begin
      restart = 1'b1;
      s_nxt.phase = is_master ? link_mon_pkg::PH_IDLE :
                    link_mon_pkg::PH_REQ;
      err_stn = frm_src;
      if (!frm_fmt_ok) begin
        err_v = 1'b1; // R4
        err_code = link_mon_pkg::E_FMT_S;
      end else if (s_r.phase == link_mon_pkg::PH_RSP &&
                   frm_src != s_r.exp_dst) begin
        err_v = 1'b1; // R2
        err_code = is_master ? link_mon_pkg::E_STN_M :
                   link_mon_pkg::E_STN_S;
      end else if (s_r.phase == link_mon_pkg::PH_RSP &&
                   frm_cnt != s_r.exp_cnt) begin
        err_v = 1'b1; // R3
        err_code = is_master ? link_mon_pkg::E_CNT_M :
                   link_mon_pkg::E_CNT_S;
      end
    end else if (expire) begin
      restart = 1'b1;
      s_nxt.active = 1'b0;
      if (s_r.phase == link_mon_pkg::PH_RSP) begin
        err_v = 1'b1;
        err_stn = s_r.exp_dst;
        err_code = is_master ? link_mon_pkg::E_NORESP : // R1
                   link_mon_pkg::E_ABSENT; // R7
        s_nxt.phase = is_master ? link_mon_pkg::PH_IDLE :
                      link_mon_pkg::PH_REQ;
      end else begin
        err_v = 1'b1; // R5
        err_stn = link_mon_pkg::MASTER_STN;
        err_code = link_mon_pkg::E_MTMO;
        s_nxt.phase = link_mon_pkg::PH_IDLE;
      end
    end
    // A fault marks the station that committed it, never ourselves.
    if (err_v) begin
      s_nxt.irq_st[link_mon_pkg::I_SEQ] = 1'b1;
      if (err_stn == link_mon_pkg::MASTER_STN) begin
        if (!is_master) begin
          s_nxt.master_flag = 1'b1; // R10
        end
      end else if (err_stn != s_r.station) begin
        s_nxt.slave_flags[err_stn - 3'h1] = 1'b1; // R11
      end
    end
    // Channel faults are sticky and win over a clear.
    if (ch1_fault) begin
      s_nxt.ch1_err = 1'b1; // R13
      s_nxt.irq_st[link_mon_pkg::I_CH1] = 1'b1;
    end
    if (ch2_fault) begin
      s_nxt.ch2_err = 1'b1; // R13
      s_nxt.irq_st[link_mon_pkg::I_CH2] = 1'b1;
    end
    // Monitoring timer in units of UNIT_CYCLES clocks.
    if (restart) begin
      s_nxt.pre = 32'h00000000;
      s_nxt.units = 8'h00;
    end else if (s_r.phase != link_mon_pkg::PH_IDLE) begin
      if (s_r.pre == 32'(UNIT_CYCLES - 1)) begin
        s_nxt.pre = 32'h00000000;
        if (s_r.units != 8'hFF) begin
          s_nxt.units = s_r.units + 8'h01;
        end
      end else begin
        s_nxt.pre = s_r.pre + 32'h00000001;
      end
    end
  end

  // State register.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r <= '0;
      s_r.mon_time <= link_mon_pkg::MON_TIME_RST;
      s_r.phase <= link_mon_pkg::PH_IDLE;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Error-code store ports; the code lands in the faulty station word.
  assign em.wr_en = err_v; // R9
  assign em.wr_addr = err_stn;
  assign em.wr_data = err_code; // R19
  assign em.rd_addr = araddr[4:2];

  // Outputs.
  assign awready = !s_r.aw_hold && !s_r.bvalid;
  assign wready = !s_r.w_hold && !s_r.bvalid;
  assign bvalid = s_r.bvalid;
  assign bresp = s_r.bresp;
  assign arready = !s_r.rd_pend && !s_r.rvalid;
  assign rvalid = s_r.rvalid;
  assign rdata = s_r.rdata;
  assign rresp = s_r.rresp;
  assign channel_select_bit = s_r.chsel;
  assign irq = |(s_r.irq_st & s_r.irq_mask);
endmodule
`default_nettype wire

// *** multidrop_link_error_monitor_assertions.sv ***
// Purpose: Port-level checks of the link error monitor.
// Assumes: Writes carry all strobes; one access of each kind at a time.
// Notes: Shadows follow station, run and the last bus addresses.
`timescale 1ns/10ps
`default_nettype none
module multidrop_link_error_monitor_assertions (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus.
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic [31:0] wdata,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  // Channel steering.
  input wire logic channel_select_bit
);
  logic [7:0] aw_q, ar_q;
  logic [31:0] wd_q;
  logic [2:0] stn_q;
  logic run_q;
  // Station and run are taken over when the write answers, never earlier.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_q <= 8'h00;
      ar_q <= 8'h00;
      wd_q <= 32'h0;
      stn_q <= 3'h0;
      run_q <= 1'h0;
    end else begin
      if (awvalid && awready) aw_q <= awaddr;
      if (wvalid && wready) wd_q <= wdata;
      if (arvalid && arready) ar_q <= araddr;
      if ($rose(bvalid) && aw_q == link_mon_pkg::A_STN) stn_q <= wd_q[2:0];
      if ($rose(bvalid) && aw_q == link_mon_pkg::A_CTRL) run_q <= wd_q[0];
    end
  end
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence s_flags;
    rvalid && ar_q == link_mon_pkg::A_FLAGS;
  endsequence
  sequence s_word;
    rvalid && ar_q >= link_mon_pkg::A_ERR_LO && ar_q[1:0] == 2'h0 &&
      ar_q <= link_mon_pkg::A_ERR_HI;
  endsequence
  sequence s_ctrl;
    $rose(bvalid) && aw_q == link_mon_pkg::A_CTRL;
  endsequence
  property p_chsel;
    s_ctrl |-> channel_select_bit == wd_q[link_mon_pkg::C_CHSEL];
  endproperty
  a_chsel: assert property (p_chsel) else $error("channel select lost");
  property p_master;
    s_flags ##0 stn_q == 3'h0 |-> !rdata[link_mon_pkg::F_MASTER];
  endproperty
  a_master: assert property (p_master) else $error("master flag on master");
  property p_own;
    s_flags ##0 stn_q != 3'h0 |-> !rdata[link_mon_pkg::F_SLAVE + stn_q - 1];
  endproperty
  a_own: assert property (p_own) else $error("own flag set");
  property p_idle;
    s_flags ##0 !run_q |-> rdata[11:3] == 9'h000;
  endproperty
  a_idle: assert property (p_idle) else $error("flags while stopped");
  property p_param;
    s_flags ##0 !run_q |-> !rdata[link_mon_pkg::F_PARAM];
  endproperty
  a_param: assert property (p_param) else $error("param flag stuck");
  property p_width;
    s_word |-> rdata[31:8] == 24'h000000;
  endproperty
  a_width: assert property (p_width) else $error("code too wide");
  property p_code;
    s_word |-> rdata[7:0] inside {8'h00, 8'h01, 8'h02, 8'h03, 8'h04,
      8'h11, 8'h14, 8'h21, 8'h22, 8'h23, 8'h31};
  endproperty
  a_code: assert property (p_code) else $error("unknown code");
  property p_word;
    s_word |-> rresp == link_mon_pkg::RESP_OKAY;
  endproperty
  a_word: assert property (p_word) else $error("word not mapped");
endmodule
bind multidrop_link_error_monitor multidrop_link_error_monitor_assertions chk (
  .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wvalid, .wready,
  .bvalid, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
  .channel_select_bit
);
`default_nettype wire

// *** link_peer_model.sv ***
// Purpose: Stand-in for the other stations on the shared line.
// Assumes: Frames reach the monitor already decoded, one per pulse.
// Notes: Between frames the fields carry the inverse of the last frame.
`timescale 1ns/10ps
`default_nettype none
module link_peer_model (
  // Clock.
  input wire logic aclk,
  // Decoded frame.
  output logic frm_valid,
  output logic frm_is_req,
  output logic frm_is_param,
  output logic [2:0] frm_src,
  output logic [2:0] frm_dst,
  output logic [7:0] frm_cnt,
  output logic frm_fmt_ok
);
  // Quiet line at time zero.
  initial begin
    frm_valid = 1'h0;
    {frm_is_req, frm_is_param, frm_src, frm_dst, frm_cnt, frm_fmt_ok} = '0;
  end
  // One frame for one clock; the fields are turned over afterwards so the
  // monitor cannot lean on stale values.
  task automatic send(input logic q, p, input logic [2:0] s, d,
                      input logic [7:0] c, input logic k);
    @(posedge aclk);
    frm_valid <= 1'h1;
    {frm_is_req, frm_is_param, frm_src, frm_dst, frm_cnt, frm_fmt_ok} <=
      {q, p, s, d, c, k};
    @(posedge aclk);
    frm_valid <= 1'h0;
    {frm_is_req, frm_is_param, frm_src, frm_dst, frm_cnt, frm_fmt_ok} <=
      ~{q, p, s, d, c, k};
  endtask
endmodule
`default_nettype wire

// *** test_multidrop_link_error_monitor.sv ***
// Purpose: Self-checking bench of the link error monitor.
// Assumes: Monitoring unit shortened to four clocks.
// Notes: Master checks run first, then slave checks as station 3.
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) \
  begin \
    checked++; \
    if ((g) !== (e)) begin \
      fails++; \
      $display("unexpected %s: expected %0h, seen %0h", nm, e, g); \
    end \
  end
module test_multidrop_link_error_monitor;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hF;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
  logic arvalid = 1'h0, rready = 1'h0, ch1_fault = 1'h0, ch2_fault = 1'h0;
  logic awready, wready, bvalid, arready, rvalid, channel_select_bit, irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic frm_valid, frm_is_req, frm_is_param, frm_fmt_ok;
  logic [2:0] frm_src, frm_dst;
  logic [7:0] frm_cnt;
  int fails = 0, checked = 0;
  // Free-running bus clock.
  always #25 aclk = ~aclk;
  multidrop_link_error_monitor #(.UNIT_CYCLES(4)) dut (
    .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
    .rresp, .rvalid, .rready, .frm_valid, .frm_is_req, .frm_is_param,
    .frm_src, .frm_dst, .frm_cnt, .frm_fmt_ok, .ch1_fault, .ch2_fault,
    .channel_select_bit, .irq
  );
  link_peer_model peer (
    .aclk, .frm_valid, .frm_is_req, .frm_is_param, .frm_src, .frm_dst,
    .frm_cnt, .frm_fmt_ok
  );
  // Verdict and end of run.
  task automatic end_of_test(input int extra);
    fails += extra;
    if (fails == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Write: address and data offered together, each dropped when taken.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
      n++;
    end while (!bvalid && n < 40);
    bready <= 1'h0;
    if (n >= 40) end_of_test(1);
    else `CHK("bresp", link_mon_pkg::RESP_OKAY, bresp)
  endtask
  // Read and compare the masked word and the response code.
  task automatic rc(input logic [7:0] a, input logic [31:0] e, m,
                    input logic bad);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'h0;
      n++;
    end while (!rvalid && n < 40);
    rready <= 1'h0;
    if (n >= 40) end_of_test(1);
    else `CHK($sformatf("reg %h", a), {bad ? 2'h3 : 2'h0, e}, {rresp, rdata & m})
  endtask
  // Send a frame, let it settle, then read one station's code word.
  task automatic fc(input logic q, p, input logic [2:0] s, d,
                    input logic [7:0] c, input logic k, input int wt,
                    input logic [2:0] w, input logic [7:0] code);
    peer.send(q, p, s, d, c, k);
    repeat (wt) @(posedge aclk);
    rc(link_mon_pkg::A_ERR_LO + {3'h0, w, 2'h0}, {24'h0, code}, '1, 1'h0);
  endtask
  // Main sequence.
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'h1;
    rc(link_mon_pkg::A_MON, 32'h5, 32'hFF, 1'h0);
    rc(8'h18, 32'h0, '1, 1'h1);
    rc(link_mon_pkg::A_FLAGS, 32'h0, 32'hFFF, 1'h0);
    @(posedge aclk);
    ch1_fault <= 1'h1;
    @(posedge aclk);
    ch1_fault <= 1'h0;
    @(posedge aclk);
    `CHK("irq", 1'h0, irq)
    wr(link_mon_pkg::A_IRQ_MASK, 32'h2);
    `CHK("irq", 1'h1, irq)
    rc(link_mon_pkg::A_FLAGS, 32'h2, 32'h6, 1'h0);
    wr(link_mon_pkg::A_IRQ_ST, 32'h2);
    `CHK("irq", 1'h0, irq)
    wr(link_mon_pkg::A_CTRL, 32'h3);
    @(posedge aclk);
    ch2_fault <= 1'h1;
    @(posedge aclk);
    ch2_fault <= 1'h0;
    peer.send(1'h1, 1'h1, 3'h0, 3'h1, 8'h07, 1'h1);
    fc(1'h0, 1'h0, 3'h2, 3'h0, 8'h07, 1'h1, 2, 3'h2, 8'h02);
    fc(1'h1, 1'h1, 3'h0, 3'h3, 8'h07, 1'h1, 30, 3'h3, 8'h01);
    peer.send(1'h1, 1'h1, 3'h0, 3'h4, 8'h09, 1'h1);
    fc(1'h0, 1'h0, 3'h4, 3'h0, 8'h08, 1'h1, 2, 3'h4, 8'h03);
    peer.send(1'h1, 1'h1, 3'h0, 3'h5, 8'h01, 1'h1);
    fc(1'h0, 1'h0, 3'h5, 3'h0, 8'h01, 1'h0, 2, 3'h5, 8'h04);
    rc(link_mon_pkg::A_FLAGS, 32'h9E5, 32'hFFF, 1'h0);
    wr(link_mon_pkg::A_CTRL, 32'h0);
    rc(link_mon_pkg::A_FLAGS, 32'h0, 32'hFFF, 1'h0);
    wr(link_mon_pkg::A_STN, 32'h3);
    wr(link_mon_pkg::A_CTRL, 32'h1);
    fc(1'h1, 1'h0, 3'h0, 3'h3, 8'h00, 1'h1, 2, 3'h3, 8'h31);
    fc(1'h1, 1'h0, 3'h0, 3'h2, 8'h00, 1'h0, 2, 3'h0, 8'h14);
    fc(1'h1, 1'h1, 3'h0, 3'h5, 8'h02, 1'h1, 30, 3'h5, 8'h21);
    peer.send(1'h1, 1'h1, 3'h0, 3'h6, 8'h02, 1'h1);
    fc(1'h0, 1'h0, 3'h7, 3'h0, 8'h02, 1'h1, 2, 3'h7, 8'h22);
    peer.send(1'h1, 1'h1, 3'h0, 3'h1, 8'h02, 1'h1);
    fc(1'h0, 1'h0, 3'h1, 3'h0, 8'h03, 1'h1, 2, 3'h1, 8'h23);
    peer.send(1'h1, 1'h1, 3'h0, 3'h2, 8'h02, 1'h1);
    fc(1'h0, 1'h0, 3'h2, 3'h0, 8'h02, 1'h0, 30, 3'h0, 8'h11);
    rc(link_mon_pkg::A_ERR_LO + 8'h08, 32'h04, '1, 1'h0);
    rc(link_mon_pkg::A_FLAGS, 32'h539, 32'hFFF, 1'h0);
    end_of_test(0);
  end
endmodule
`default_nettype wire
